// [logic/ppcd_regs.svh]
// Function
// - Entry is function word plus data word.
// - Speed selector picks one of sixteen presets.
// - Delay selector bits 23:20 set delay.
// - Type 7 jumps to procedure 0..63.
// - Jump honours only insert bit 4.
// - Type 8 writes the target parameter.
// - Bit 6 also commits write to EEPROM.
// - Bit 5 auto-advances after the write.
// - Target group bits 19:16, BCD number 15:8.
// - Bit 26 picks constant or parameter source.
// - Source group/index low, upper bits zero.
// - Alarms 63, 61, 62 for bad source.
// - Write alarm suppresses automatic advance.
// - Type A index move, 0..4194304 pulses.
// - Bits 7:6 pick forward, reverse, shortest.
// - Overlap passed on; delay should be zero.
// - Accel and decel selectors pick presets.
// - Bit 24 selects 0.01 rpm speed unit.
// - Extra bit 26 auto-advances after index.
`ifndef PPCD_REGS_SVH
`define PPCD_REGS_SVH

// Register indices on the three-bit address port.
`define PPCD_A_FUNC      3'h0
`define PPCD_A_DATA      3'h1
`define PPCD_A_CTRL      3'h2
`define PPCD_A_STAT      3'h3
`define PPCD_CTRL_START  0
`define PPCD_CTRL_CLR    1
`define PPCD_WORD_RST    32'h0000_0000

// Function word fields.
`define PPCD_F_TYPE      3:0
`define PPCD_F_ACCEL     11:8
`define PPCD_F_DECEL     15:12
`define PPCD_F_SPEED     19:16
`define PPCD_F_DELAY     23:20
`define PPCD_F_DIR       7:6
`define PPCD_F_TGRP      19:16
`define PPCD_F_TNUM      15:8
`define PPCD_B_INSERT    4
`define PPCD_B_OVERLAP   5
`define PPCD_B_AUTO      5
`define PPCD_B_ROM       6
`define PPCD_B_SRC       26
`define PPCD_B_FINE      24
`define PPCD_B_IAUTO     26

// Data word fields.
`define PPCD_F_JHIGH     31:6
`define PPCD_F_JNUM      5:0
`define PPCD_F_RSVD      31:12
`define PPCD_F_SGRP      11:8
`define PPCD_F_SIDX      7:0
`define PPCD_F_COORD     22:0

// Command types and limits.
`define PPCD_T_JUMP      4'h7
`define PPCD_T_WRITE     4'h8
`define PPCD_T_INDEX     4'ha
`define PPCD_INDEX_MAX   32'h0040_0000
`define PPCD_GRP_MIN     4'h1
`define PPCD_GRP_MAX     4'h6
`define PPCD_BCD_MAX     4'h9
`define PPCD_DIR_FWD     2'b00
`define PPCD_DIR_REV     2'b01
`define PPCD_DIR_SHORT   2'b10

// Alarm codes.
`define PPCD_AL_GRP      8'h3d
`define PPCD_AL_IDX      8'h3e
`define PPCD_AL_RSVD     8'h3f
`define PPCD_AL_STORE    8'h40
`define PPCD_AL_NONE     8'h00

// Delay presets count milliseconds.
`define PPCD_MS_NS       1000000
`define PPCD_CLK_NS      50

`endif

// [logic/ppcd_pkg.sv]
package ppcd_pkg;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_DELAY = 3'b001,
    S_SRC   = 3'b010,
    S_WR    = 3'b011,
    S_MOVE  = 3'b100
  } state_t;

  typedef logic [31:0] word_t;
  typedef logic [3:0]  sel_t;
  typedef logic [7:0]  alarm_t;

endpackage : ppcd_pkg

// [logic/procedure_path_command_decoder.sv]
`timescale 1ns/10ps
`include "ppcd_regs.svh"

module procedure_path_command_decoder #(
  parameter int unsigned CYCLES_PER_MS = `PPCD_MS_NS / `PPCD_CLK_NS
) (
  // Clock and reset.
  input  wire logic            i_clk,
  input  wire logic            i_rst,
  // Register port.
  input  wire logic [2:0]      i_addr,
  input  wire ppcd_pkg::word_t i_wdata,
  input  wire logic            i_wr,
  input  wire logic            i_rd,
  output ppcd_pkg::word_t      o_rdata,
  // Preset selectors toward the parameter store.
  output ppcd_pkg::sel_t       o_speed_preset_select,
  output ppcd_pkg::sel_t       o_delay_preset_select,
  output ppcd_pkg::sel_t       o_accel_preset_select,
  output ppcd_pkg::sel_t       o_decel_preset_select,
  input  wire logic [15:0]     i_delay_ms,
  // Source parameter read.
  output logic                 o_src_req,
  output logic [3:0]           o_src_grp,
  output logic [7:0]           o_src_idx,
  input  wire logic            i_src_valid,
  input  wire ppcd_pkg::word_t i_src_data,
  // Parameter write.
  output logic                 o_wr_req,
  output logic [3:0]           o_wr_grp,
  output logic [7:0]           o_wr_num,
  output ppcd_pkg::word_t      o_wr_data,
  output logic                 o_wr_eeprom,
  input  wire logic            i_wr_done,
  input  wire logic            i_wr_fail,
  // Jump.
  output logic                 o_jump,
  output logic [5:0]           o_jump_target,
  output logic                 o_jump_insert,
  // Index move.
  input  wire logic [22:0]     i_present_pos,
  input  wire logic [22:0]     i_index_span,
  input  wire logic            i_motion_done,
  output logic                 o_index,
  output logic [22:0]          o_index_coord,
  output logic                 o_index_reverse,
  output logic                 o_index_overlap,
  output logic                 o_index_insert,
  output logic                 o_speed_fine,
  // Sequencing and alarms.
  output logic                 o_auto_next,
  output logic                 o_invalid,
  output logic                 o_busy,
  output ppcd_pkg::alarm_t     o_alarm_code
);

  import ppcd_pkg::*;

  localparam logic [14:0] MS_LAST = 15'(CYCLES_PER_MS - 1);

  // ==========================================================================
  // Entry registers and decode
  // ==========================================================================
  word_t       func;
  word_t       data;
  state_t      state;
  state_t      next_state;
  logic [14:0] ms_cnt;
  logic [15:0] delay_left;
  logic        invalid_seen;

  wire [3:0] cmd_type  = func[`PPCD_F_TYPE];
  wire       is_jump   = cmd_type == `PPCD_T_JUMP;
  wire       is_write  = cmd_type == `PPCD_T_WRITE;
  wire       is_index  = cmd_type == `PPCD_T_INDEX;
  wire       jump_ok   = data[`PPCD_F_JHIGH] == 26'h0;
  wire       index_ok  = data <= `PPCD_INDEX_MAX;
  wire       type_ok   = (is_jump & jump_ok) | is_write |
                         (is_index & index_ok);

  // Out-of-range jump and index data are refused at start, so nothing
  // downstream ever sees a target that cannot exist.
  wire       wr_start  = i_wr & (i_addr == `PPCD_A_CTRL);
  wire       start     = wr_start & i_wdata[`PPCD_CTRL_START] &
                         (state == S_IDLE);
  wire       clr       = wr_start & i_wdata[`PPCD_CTRL_CLR];
  wire       entry_wr  = i_wr & (state == S_IDLE);

  // Decimal digit checks for target number and source index.
  wire [7:0] tnum = func[`PPCD_F_TNUM];
  wire [7:0] sidx = data[`PPCD_F_SIDX];
  wire [1:0] tdig_ok;
  wire [1:0] sdig_ok;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_bcd
      assign tdig_ok[g] = tnum[4*g +: 4] <= `PPCD_BCD_MAX;
      assign sdig_ok[g] = sidx[4*g +: 4] <= `PPCD_BCD_MAX;
    end
  endgenerate

  wire [3:0] tgrp   = func[`PPCD_F_TGRP];
  wire [3:0] sgrp   = data[`PPCD_F_SGRP];
  wire       tgrp_ok = (tgrp >= `PPCD_GRP_MIN) & (tgrp <= `PPCD_GRP_MAX);
  wire       sgrp_ok = (sgrp >= `PPCD_GRP_MIN) & (sgrp <= `PPCD_GRP_MAX);
  wire       from_par = func[`PPCD_B_SRC];
  wire       rsvd_bad = from_par & (data[`PPCD_F_RSVD] != 20'h0);

  // The reserved check outranks the range checks, so a garbage word
  // reports the most telling cause first.
  wire       grp_bad  = ~tgrp_ok | (from_par & ~sgrp_ok);
  wire       idx_bad  = ~(&tdig_ok) | (from_par & ~(&sdig_ok));
  alarm_t    wr_alarm;
  assign     wr_alarm = rsvd_bad ? `PPCD_AL_RSVD :
                        grp_bad  ? `PPCD_AL_GRP  :
                        idx_bad  ? `PPCD_AL_IDX  : `PPCD_AL_NONE;
  wire       wr_bad   = wr_alarm != `PPCD_AL_NONE;

  // ==========================================================================
  // Shortest-way direction
  // ==========================================================================
  // The span is the coordinate length of one turn; it must exceed both
  // positions or the comparison is meaningless.
  wire [22:0] coord   = data[`PPCD_F_COORD];
  wire        ahead   = coord >= i_present_pos;
  wire [23:0] fwd_raw = ahead ? {1'b0, coord} - {1'b0, i_present_pos} :
                        {1'b0, coord} + {1'b0, i_index_span} -
                        {1'b0, i_present_pos};
  wire        short_rev = {fwd_raw, 1'b0} > {2'b00, i_index_span};
  wire [1:0]  dir_sel = func[`PPCD_F_DIR];
  wire        go_rev  = (dir_sel == `PPCD_DIR_REV) |
                        ((dir_sel == `PPCD_DIR_SHORT) & short_rev);

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  wire delay_over = (delay_left == 16'h0);
  wire ms_tick  = (ms_cnt == MS_LAST);

  always_comb begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (start & type_ok) begin
          next_state = S_DELAY;
        end
      end
      S_DELAY: begin
        if (delay_over) begin
          if (is_index) begin
            next_state = S_MOVE;
          end else if (is_write & ~wr_bad) begin
            next_state = from_par ? S_SRC : S_WR;
          end else begin
            next_state = S_IDLE;
          end
        end
      end
      S_SRC: begin
        if (i_src_valid) begin
          next_state = S_WR;
        end
      end
      S_WR: begin
        if (i_wr_done) begin
          next_state = S_IDLE;
        end
      end
      S_MOVE: begin
        if (i_motion_done) begin
          next_state = S_IDLE;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  wire leave_delay = (state == S_DELAY) & delay_over;
  wire issue_wr  = (leave_delay & is_write & ~wr_bad & ~from_par) |
                   ((state == S_SRC) & i_src_valid);
  wire wr_end    = (state == S_WR) & i_wr_done;
  wire move_end  = (state == S_MOVE) & i_motion_done;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state <= S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Delay preset counts whole milliseconds.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ms_cnt     <= 15'h0;
      delay_left <= 16'h0;
    end else if (start) begin
      ms_cnt     <= 15'h0;
      delay_left <= i_delay_ms;
    end else if ((state == S_DELAY) & ~delay_over) begin
      ms_cnt     <= ms_tick ? 15'h0 : ms_cnt + 15'h1;
      delay_left <= ms_tick ? delay_left - 16'h1 : delay_left;
    end
  end

  // ==========================================================================
  // Entry words, register port
  // ==========================================================================
  // Entry words are frozen while a command runs so the decode stays
  // stable for the whole sequence.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      func <= `PPCD_WORD_RST;
      data <= `PPCD_WORD_RST;
    end else if (entry_wr & (i_addr == `PPCD_A_FUNC)) begin
      func <= i_wdata;
    end else if (entry_wr & (i_addr == `PPCD_A_DATA)) begin
      data <= i_wdata;
    end
  end

  // Read data fall back to zero outside a reply, so a late sample of the
  // port never shows stale register contents.
  word_t stat_word;
  word_t rd_mux;
  assign stat_word = {16'h0, o_alarm_code, 6'h0, invalid_seen, o_busy};
  assign rd_mux = (i_addr == `PPCD_A_FUNC) ? func :
                  (i_addr == `PPCD_A_DATA) ? data :
                  (i_addr == `PPCD_A_STAT) ? stat_word : `PPCD_WORD_RST;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= `PPCD_WORD_RST;
    end else begin
      o_rdata <= i_rd ? rd_mux : `PPCD_WORD_RST;
    end
  end

  // ==========================================================================
  // Alarm and status
  // ==========================================================================
  wire set_alarm = leave_delay & is_write & wr_bad;
  wire set_store = wr_end & i_wr_fail;
  wire set_inv   = start & ~type_ok;

  // A new alarm or invalid event beats a clear in the same cycle.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_alarm_code <= `PPCD_AL_NONE;
      invalid_seen <= 1'b0;
      o_busy       <= 1'b0;
    end else begin
      o_busy <= next_state != S_IDLE;
      if (set_alarm) begin
        o_alarm_code <= wr_alarm;
      end else if (set_store) begin
        o_alarm_code <= `PPCD_AL_STORE;
      end else if (clr) begin
        o_alarm_code <= `PPCD_AL_NONE;
      end
      if (set_inv) begin
        invalid_seen <= 1'b1;
      end else if (clr) begin
        invalid_seen <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Command outputs
  // ==========================================================================
  assign o_speed_preset_select = func[`PPCD_F_SPEED];
  assign o_delay_preset_select = func[`PPCD_F_DELAY];
  assign o_accel_preset_select = func[`PPCD_F_ACCEL];
  assign o_decel_preset_select = func[`PPCD_F_DECEL];

  wire auto_wr  = wr_end & ~i_wr_fail & func[`PPCD_B_AUTO];
  wire auto_idx = move_end & func[`PPCD_B_IAUTO];

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_src_req   <= 1'b0;
      o_src_grp   <= 4'h0;
      o_src_idx   <= 8'h0;
      o_wr_req    <= 1'b0;
      o_wr_grp    <= 4'h0;
      o_wr_num    <= 8'h0;
      o_wr_data   <= `PPCD_WORD_RST;
      o_wr_eeprom <= 1'b0;
    end else begin
      o_src_req <= leave_delay & is_write & ~wr_bad & from_par;
      o_wr_req  <= issue_wr;
      if (leave_delay & is_write) begin
        o_src_grp   <= sgrp;
        o_src_idx   <= sidx;
        o_wr_grp    <= tgrp;
        o_wr_num    <= tnum;
        o_wr_eeprom <= func[`PPCD_B_ROM];
      end
      if (issue_wr) begin
        o_wr_data <= from_par ? i_src_data : data;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_jump          <= 1'b0;
      o_jump_target   <= 6'h0;
      o_jump_insert   <= 1'b0;
      o_index         <= 1'b0;
      o_index_coord   <= 23'h0;
      o_index_reverse <= 1'b0;
      o_index_overlap <= 1'b0;
      o_index_insert  <= 1'b0;
      o_speed_fine    <= 1'b0;
      o_auto_next     <= 1'b0;
      o_invalid       <= 1'b0;
    end else begin
      o_jump      <= leave_delay & is_jump;
      o_index     <= leave_delay & is_index;
      o_auto_next <= auto_wr | auto_idx;
      o_invalid   <= set_inv;
      if (leave_delay & is_jump) begin
        o_jump_target <= data[`PPCD_F_JNUM];
        o_jump_insert <= func[`PPCD_B_INSERT];
      end
      if (leave_delay & is_index) begin
        o_index_coord   <= coord;
        o_index_reverse <= go_rev;
        o_index_overlap <= func[`PPCD_B_OVERLAP];
        o_index_insert  <= func[`PPCD_B_INSERT];
        o_speed_fine    <= func[`PPCD_B_FINE];
      end
    end
  end

endmodule : procedure_path_command_decoder

// [test/ppcd_properties.sv]
`timescale 1ns/10ps
// ====================================================================
// Port checks for the procedure decoder.
module ppcd_properties #(
  parameter int unsigned CYCLES_PER_MS = 4
) (
  input wire logic              i_clk,
  input wire logic              i_rst,
  input wire logic [2:0]        i_addr,
  input wire ppcd_pkg::word_t   i_wdata,
  input wire logic              i_wr,
  input wire logic              i_rd,
  input wire ppcd_pkg::word_t   o_rdata,
  input wire ppcd_pkg::sel_t    o_speed_preset_select,
  input wire ppcd_pkg::sel_t    o_delay_preset_select,
  input wire logic              i_src_valid,
  input wire logic              i_wr_done,
  input wire logic              i_wr_fail,
  input wire logic              i_motion_done,
  input wire logic              o_wr_req,
  input wire logic              o_jump,
  input wire logic              o_index,
  input wire logic              o_auto_next,
  input wire logic              o_invalid,
  input wire logic              o_busy,
  input wire ppcd_pkg::alarm_t  o_alarm_code
);
  import ppcd_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_start;
    i_wr && i_addr == 3'h2 && i_wdata[0] && !o_busy;
  endsequence
  sequence s_source_in;
    o_busy && i_src_valid;
  endsequence
  sequence s_store_bad;
    o_busy && i_wr_done && i_wr_fail;
  endsequence
  a_rdata_idle: assert property (
    !$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data not zero outside a reply");
  a_status_read: assert property (
    i_rd && i_addr == 3'h3 |=> o_rdata[15:8] == $past(o_alarm_code)
      && o_rdata[0] == $past(o_busy))
    else $error("status read does not match alarm or busy");
  a_select_load: assert property (
    i_wr && i_addr == 3'h0 && !o_busy |=>
      o_speed_preset_select == $past(i_wdata[19:16])
      && o_delay_preset_select == $past(i_wdata[23:20]))
    else $error("preset selectors do not follow the function word");
  a_start_busy: assert property (
    s_start |=> o_busy != o_invalid)
    else $error("start neither runs nor flags invalid");
  a_invalid_quiet: assert property (
    o_invalid |=> (!o_wr_req && !o_jump && !o_index)[*4])
    else $error("invalid entry issued an action");
  a_source_write: assert property (
    s_source_in |=> o_wr_req)
    else $error("source value not written on the next cycle");
  a_store_alarm: assert property (
    s_store_bad |=> o_alarm_code == 8'h40 && !o_auto_next)
    else $error("store failure not alarmed or advance not held");
  a_auto_cause: assert property (
    o_auto_next |-> $past(i_wr_done && !i_wr_fail) || $past(i_motion_done))
    else $error("advance without a completed command");
  a_pulse_single: assert property (
    o_wr_req || o_jump || o_index |=> !o_wr_req && !o_jump && !o_index)
    else $error("action pulse longer than one cycle");
endmodule : ppcd_properties

bind procedure_path_command_decoder ppcd_properties #(
  .CYCLES_PER_MS(CYCLES_PER_MS)
) u_ppcd_properties (
  .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_speed_preset_select(o_speed_preset_select),
  .o_delay_preset_select(o_delay_preset_select),
  .i_src_valid(i_src_valid), .i_wr_done(i_wr_done),
  .i_wr_fail(i_wr_fail), .i_motion_done(i_motion_done),
  .o_wr_req(o_wr_req), .o_jump(o_jump), .o_index(o_index),
  .o_auto_next(o_auto_next), .o_invalid(o_invalid), .o_busy(o_busy),
  .o_alarm_code(o_alarm_code));

// [test/ppcd_partner.sv]
`timescale 1ns/10ps
// ====================================================================
// Parameter store and trajectory generator, answering after LAT cycles.
module ppcd_partner #(
  parameter int LAT = 3
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_fail,
  input  wire logic        i_src_req,
  input  wire logic [3:0]  i_grp,
  input  wire logic [7:0]  i_idx,
  input  wire logic        i_wr_req,
  input  wire logic        i_index,
  output logic             o_src_valid,
  output logic [31:0]      o_src_data,
  output logic             o_wr_done,
  output logic             o_wr_fail,
  output logic             o_motion_done
);
  int          cs;
  int          cw;
  int          cm;
  logic [31:0] val;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cs <= 0;
      cw <= 0;
      cm <= 0;
      val <= 32'h0;
      o_src_valid <= 1'b0;
      o_src_data <= 32'h0;
      o_wr_done <= 1'b0;
      o_wr_fail <= 1'b0;
      o_motion_done <= 1'b0;
    end else begin
      cs <= i_src_req ? LAT : (cs > 0 ? cs - 1 : 0);
      cw <= i_wr_req ? LAT : (cw > 0 ? cw - 1 : 0);
      cm <= i_index ? LAT : (cm > 0 ? cm - 1 : 0);
      if (i_src_req) begin
        val <= {16'ha5c3, i_grp, 4'h0, i_idx};
      end
      o_src_valid <= (cs == 1);
      // Outside a reply the data and fail lines keep changing on purpose.
      o_src_data <= (cs == 1) ? val : ~o_src_data;
      o_wr_done <= (cw == 1);
      o_wr_fail <= (cw == 1) ? i_fail : ~o_wr_fail;
      o_motion_done <= (cm == 1);
    end
  end
endmodule : ppcd_partner

// [test/tb_top.sv]
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  import ppcd_pkg::*;
  typedef struct packed {
    word_t       f;
    word_t       d;
    logic [2:0]  k;
    word_t       v;
    logic [12:0] x;
    alarm_t      a;
    logic        n;
  } row_t;
  logic        i_clk, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, fail = 1'b0;
  logic [2:0]  i_addr = 3'h0, gk = 3'h0;
  word_t       i_wdata = 32'h0, o_rdata, src_data, wr_data, gv, rv;
  logic [15:0] i_delay_ms = 16'h0;
  sel_t        speed_sel, delay_sel, accel_sel, decel_sel;
  logic        src_req, src_valid, wr_req, wr_done, wr_fail, wr_eep;
  logic        jump, jins, mdone, index, rev, ovl, fine, auto, inv;
  logic        busy, ga, idx_insert;
  logic [3:0]  src_grp, wr_grp;
  logic [7:0]  src_idx, wr_num;
  logic [5:0]  jtgt;
  logic [22:0] coord, pos = 23'd0;
  logic [12:0] gx;
  alarm_t      alarm;
  int          err_count = 0, tests_run = 0, cyc = 0;
  time         t0, tj;
  row_t        r;
  row_t        rows [11] = '{
    '{32'h0000_00f7, 32'h3f, 3'd1, 32'h3f, 13'h1, 8'h0, 1'b0},
    '{32'h0000_0017, 32'h40, 3'd4, 32'h0, 13'h0, 8'h0, 1'b0},
    '{32'h0006_3468, 32'h1234_5678, 3'd2, 32'h1234_5678,
      {4'h6, 8'h34, 1'b1}, 8'h0, 1'b1},
    '{32'h0401_0528, 32'h245, 3'd2, 32'ha5c3_2045,
      {4'h1, 8'h05, 1'b0}, 8'h0, 1'b1},
    '{32'h0401_0528, 32'h10_0245, 3'd0, 32'h0, 13'h0, 8'h3f, 1'b0},
    '{32'h0401_0528, 32'h745, 3'd0, 32'h0, 13'h0, 8'h3d, 1'b0},
    '{32'h0401_0528, 32'h24a, 3'd0, 32'h0, 13'h0, 8'h3e, 1'b0},
    '{32'h0500_004a, 32'h40_0000, 3'd3, 32'h40_0000, 13'h3, 8'h0,
      1'b1},
    '{32'h0000_000a, 32'h40_0001, 3'd4, 32'h0, 13'h0, 8'h0, 1'b0},
    '{32'h0000_00ba, 32'h384, 3'd3, 32'h384, 13'hd, 8'h0, 1'b0},
    '{32'h0000_0001, 32'h64, 3'd4, 32'h0, 13'h0, 8'h0, 1'b0}};

  // ==================================================================
  // Design, far side and clock.
  procedure_path_command_decoder #(
    .CYCLES_PER_MS(4)
  ) u_procedure_path_command_decoder (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_speed_preset_select(speed_sel), .o_delay_preset_select(delay_sel),
    .o_accel_preset_select(accel_sel), .o_decel_preset_select(decel_sel),
    .i_delay_ms(i_delay_ms), .o_src_req(src_req), .o_src_grp(src_grp),
    .o_src_idx(src_idx), .i_src_valid(src_valid), .i_src_data(src_data),
    .o_wr_req(wr_req), .o_wr_grp(wr_grp), .o_wr_num(wr_num),
    .o_wr_data(wr_data), .o_wr_eeprom(wr_eep), .i_wr_done(wr_done),
    .i_wr_fail(wr_fail), .o_jump(jump), .o_jump_target(jtgt),
    .o_jump_insert(jins), .i_present_pos(pos), .i_index_span(23'd1000),
    .i_motion_done(mdone), .o_index(index), .o_index_coord(coord),
    .o_index_reverse(rev), .o_index_overlap(ovl),
    .o_index_insert(idx_insert),
    .o_speed_fine(fine), .o_auto_next(auto), .o_invalid(inv),
    .o_busy(busy), .o_alarm_code(alarm));
  ppcd_partner #(.LAT(3)) u_ppcd_partner (
    .i_clk(i_clk), .i_rst(i_rst), .i_fail(fail), .i_src_req(src_req),
    .i_grp(src_grp), .i_idx(src_idx), .i_wr_req(wr_req), .i_index(index),
    .o_src_valid(src_valid), .o_src_data(src_data), .o_wr_done(wr_done),
    .o_wr_fail(wr_fail), .o_motion_done(mdone));
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // Later pulses override an invalid flag, so a stray action shows up.
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      tally_and_finish();
    end
    // A start clears the capture, so each run sees only its own actions.
    if (i_wr && i_addr == 3'h2 && i_wdata[0]) begin
      gk <= 3'd0;
      ga <= 1'b0;
    end
    if (inv) gk <= 3'd4;
    if (jump) begin
      gk <= 3'd1;
      gv <= {26'h0, jtgt};
      gx <= {12'h0, jins};
      tj <= $time;
    end
    if (wr_req) begin
      gk <= 3'd2;
      gv <= wr_data;
      gx <= {wr_grp, wr_num, wr_eep};
    end
    if (index) begin
      gk <= 3'd3;
      gv <= {9'h0, coord};
      gx <= {9'h0, idx_insert, ovl, fine, rev};
    end
    if (auto) ga <= 1'b1;
  end

  // ==================================================================
  // Bus cycles and one entry run.
  task automatic wr(input logic [2:0] a, input word_t d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output word_t v);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask : rd

  task automatic run(input row_t e);
    wr(3'h0, e.f);
    wr(3'h1, e.d);
    wr(3'h2, 32'h1);
    repeat (3) @(posedge i_clk);
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge i_clk);
    `CHK(busy, 1'b0)
    repeat (3) @(posedge i_clk);
    `CHK(gk, e.k)
    if (e.k inside {3'd1, 3'd2, 3'd3}) begin
      `CHK(gv, e.v)
      `CHK(gx, e.x)
    end
    `CHK(ga, e.n)
    `CHK(alarm, e.a)
  endtask : run

  task automatic tally_and_finish();
    $display("mismatches %0d of %0d checks", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    for (int a = 0; a < 6; a++) begin
      rd(3'(a), rv);
      `CHK(rv, 32'h0)
    end
    wr(3'h0, 32'h1234_5670);
    wr(3'h5, 32'hffff_ffff);
    rd(3'h0, rv);
    `CHK(rv, 32'h1234_5670)
    rd(3'h5, rv);
    `CHK(rv, 32'h0)
    for (int i = 0; i < 11; i++) begin
      run(rows[i]);
      wr(3'h2, 32'h2);
    end
    fail <= 1'b1;
    r = rows[2];
    r.a = 8'h40;
    r.n = 1'b0;
    run(r);
    rd(3'h3, rv);
    `CHK(rv, 32'h0000_4000)
    wr(3'h2, 32'h2);
    fail <= 1'b0;
    pos <= 23'd800;
    r = rows[9];
    r.x = 13'hc;
    run(r);
    pos <= 23'd0;
    r = rows[7];
    r.f = 32'h0500_000a;
    r.x = 13'h2;
    run(r);
    i_delay_ms <= 16'd2;
    wr(3'h0, 32'h0035_c9a7);
    wr(3'h1, 32'h20);
    `CHK(speed_sel, 4'h5)
    `CHK(delay_sel, 4'h3)
    `CHK({accel_sel, decel_sel}, 8'h9c)
    wr(3'h2, 32'h1);
    t0 = $time;
    wr(3'h0, 32'h1);
    rd(3'h0, rv);
    `CHK(rv, 32'h0035_c9a7)
    for (int i = 0; i < 100 && busy !== 1'b0; i++) @(posedge i_clk);
    `CHK(busy, 1'b0)
    repeat (2) @(posedge i_clk);
    `CHK((tj - t0) / 50, 64'd10)
    tally_and_finish();
  end
endmodule : tb_top
